// ===== wbwc_ctrl_regs.sv
// Watchdog, transceiver and wake control registers of the system basis chip.
// Assumes the mode logic gives one-cycle event pulses and that serial pins are synchronous.
//
// Operation
// - Watchdog config bit 6: first stop-mode watchdog disable request.
// - Watchdog config bit 5: zero time-out watchdog, one window watchdog.
// - Watchdog config bit 4: start watchdog with long window after bus wake.
// - Period codes 0..7 give 10,20,50,100,200,500,1000,10000 ms.
// - Reserved bits always read as zero.
// - Restart loads watchdog config with x0xx 0100.
// - Transceiver mode: off, wake capable, receive only, normal.
// - Restart clears bus control bits 7..2; mode comes from restart cause.
// - Fail-safe entry forces bus control to 0000 0001.
// - Development mode: power-on and soft-reset transceiver mode is normal.
// - Internal wake bit 6 enables the cyclic timer as wake source.
// - Watchdog off in stop mode only when both disable bits are one.
// - Stop to normal transition clears the second disable bit.
// - Restart clears internal wake control except the timer wake enable.
// - External wake bit 7: interrupt from wake sources only, or all status.
// - External wake bit 5 selects voltage sensing; pin then gives no wakes.
// - External wake bit 0 enables the high-voltage wake pin.
// - External wake resets to 0000 0001; restart keeps bits 7, 5, 0.
// - Fail-safe with sensing off forces external wake to x0x0 0001.
// - Setting sensing select while fail output active is refused and flagged.
`timescale 1ns/1ps
module wbwc_ctrl_regs
  import wbwc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic csn_b_i,
  input wire logic sdi_i,
  input wire logic dev_mode_i,
  input wire logic fail_out_active_i,
  input wire wbwc_pkg::wbwc_evt_t evt_i,
  output logic sdo_o,
  output logic stop_wdog_disable_a_o,
  output logic watchdog_type_select_o,
  output logic watchdog_start_on_bus_wake_o,
  output logic [2:0] watchdog_period_select_o,
  output logic [13:0] watchdog_period_ms_o,
  output logic stop_wdog_off_o,
  output logic [1:0] can_mode_o,
  output logic cyclic_timer_wake_enable_o,
  output logic stop_wdog_disable_b_o,
  output logic interrupt_scope_all_o,
  output logic voltage_sense_select_o,
  output logic wake_pin_enable_o,
  output logic wake_pin_events_o,
  output logic spi_fail_set_o
);
  import wbwc_pkg::*;

  localparam wbwc_state_t ST_POR = '{
    wd: WD_POR,
    bus: BUS_POR,
    iwk: IWK_POR,
    ewk: EWK_POR,
    init_pending: 1'b1,
    spi_fail: 1'b0,
    stop_off: 1'b0,
    pin_wake: 1'b1,
    period_ms: WD_PER_4_MS
  };

  // ==========================================================
  // Reset release
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ==========================================================
  // Serial access
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  wbwc_req_t req;
  wbwc_state_t st;
  wbwc_state_t next_st;

  wbwc_spi_frame u_spi (
    .mclk_i(mclk_i),
    .rst_b_i(rst_n),
    .sck_i(sck_i),
    .csn_b_i(csn_b_i),
    .sdi_i(sdi_i),
    .rd_data_i(rd_data),
    .addr_o(rd_addr),
    .sdo_o(sdo_o),
    .req_o(req)
  );

  // Unmapped addresses read as zero
  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      ADDR_WATCHDOG_CONFIGURATION: rd_data = st.wd & WD_MASK;
      ADDR_TRANSCEIVER_MODE_CONTROL: rd_data = st.bus & BUS_MASK;
      ADDR_INTERNAL_WAKE_CONTROL: rd_data = st.iwk & IWK_MASK;
      ADDR_EXTERNAL_WAKE_CONTROL: rd_data = st.ewk & EWK_MASK;
      default: rd_data = '0;
    endcase
  end

  // ==========================================================
  // Register update
  logic vsense_refused;

  always_comb begin
    // Sensing may not be chosen while the fail output already signals
    vsense_refused = req.valid && req.wr && req.addr == ADDR_EXTERNAL_WAKE_CONTROL
      && req.data[EWK_VSENSE_BIT] && fail_out_active_i;
    next_st = st;
    next_st.spi_fail = 1'b0;
    next_st.init_pending = 1'b0;
    // The strap is caught on the first edge after release, never by the reset
    if (st.init_pending && dev_mode_i) begin
      next_st.bus = {6'h00, CAN_NORMAL};
    end
    if (evt_i.soft_reset) begin
      next_st.wd = WD_POR;
      next_st.bus = dev_mode_i ? {6'h00, CAN_NORMAL} : BUS_POR;
      next_st.iwk = IWK_POR;
      next_st.ewk = EWK_POR;
    end else if (evt_i.restart) begin
      next_st.wd = (st.wd & WD_RST_KEEP) | WD_RST_VAL;
      next_st.bus = {6'h00, evt_i.restart_can_mode};
      next_st.iwk = st.iwk & IWK_RST_KEEP;
      next_st.ewk = st.ewk & EWK_RST_KEEP;
    end else if (evt_i.fail_safe) begin
      next_st.bus = BUS_FAIL_SAFE;
      if (!st.ewk[EWK_VSENSE_BIT]) begin
        next_st.ewk = (st.ewk & EWK_FS_KEEP) | EWK_FS_SET;
      end
    end else if (req.valid && req.wr) begin
      unique case (req.addr)
        ADDR_WATCHDOG_CONFIGURATION: begin
          // Parity is the host's duty; the check bit is stored as written
          next_st.wd = req.data & WD_MASK;
        end
        ADDR_TRANSCEIVER_MODE_CONTROL: begin
          next_st.bus = req.data & BUS_MASK;
        end
        ADDR_INTERNAL_WAKE_CONTROL: begin
          next_st.iwk = req.data & IWK_MASK;
        end
        ADDR_EXTERNAL_WAKE_CONTROL: begin
          if (vsense_refused) begin
            next_st.spi_fail = 1'b1;
          end else begin
            next_st.ewk = req.data & EWK_MASK;
          end
        end
        default: begin
          next_st.spi_fail = 1'b0;
        end
      endcase
    end
    // Hardware clear wins over a write landing in the same cycle
    if (evt_i.stop_to_normal) begin
      next_st.iwk[IWK_STOP_DISABLE_B_BIT] = 1'b0;
    end
    // Derived outputs follow the registers in the same cycle
    next_st.stop_off = next_st.wd[WD_STOP_DISABLE_A_BIT]
      && next_st.iwk[IWK_STOP_DISABLE_B_BIT];
    next_st.pin_wake = next_st.ewk[EWK_PIN_ENABLE_BIT]
      && !next_st.ewk[EWK_VSENSE_BIT];
    next_st.period_ms = wbwc_period_ms(next_st.wd[2:0]);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_POR;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign stop_wdog_disable_a_o = st.wd[WD_STOP_DISABLE_A_BIT];
  assign watchdog_type_select_o = st.wd[WD_TYPE_BIT];
  assign watchdog_start_on_bus_wake_o = st.wd[WD_BUS_WAKE_BIT];
  assign watchdog_period_select_o = st.wd[2:0];
  assign watchdog_period_ms_o = st.period_ms;
  assign stop_wdog_off_o = st.stop_off;
  assign can_mode_o = st.bus[1:0];
  assign cyclic_timer_wake_enable_o = st.iwk[IWK_TIMER_WAKE_BIT];
  assign stop_wdog_disable_b_o = st.iwk[IWK_STOP_DISABLE_B_BIT];
  assign interrupt_scope_all_o = st.ewk[EWK_INT_SCOPE_BIT];
  assign voltage_sense_select_o = st.ewk[EWK_VSENSE_BIT];
  assign wake_pin_enable_o = st.ewk[EWK_PIN_ENABLE_BIT];
  assign wake_pin_events_o = st.pin_wake;
  assign spi_fail_set_o = st.spi_fail;

  // ==========================================================
  // Checks
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (st.wd & ~WD_MASK) == 8'h00 && (st.bus & ~BUS_MASK) == 8'h00
    && (st.iwk & ~IWK_MASK) == 8'h00 && (st.ewk & ~EWK_MASK) == 8'h00)
    else $error("reserved bit holds a one");

  a_restart_wdog: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.restart && !evt_i.soft_reset |=>
      st.wd == (($past(st.wd) & WD_RST_KEEP) | WD_RST_VAL))
    else $error("watchdog config wrong after restart");

  a_restart_bus: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.restart && !evt_i.soft_reset |=>
      st.bus == {6'h00, $past(evt_i.restart_can_mode)})
    else $error("bus control wrong after restart");

  a_failsafe_bus: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.fail_safe && !evt_i.restart && !evt_i.soft_reset |=> can_mode_o == CAN_WAKE_CAPABLE)
    else $error("fail-safe did not make transceiver wake capable");

  a_failsafe_wake: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.fail_safe && !evt_i.restart && !evt_i.soft_reset && !voltage_sense_select_o
      |=> wake_pin_enable_o && wake_pin_events_o && st.ewk[EWK_INT_SCOPE_BIT]
        == $past(st.ewk[EWK_INT_SCOPE_BIT]))
    else $error("fail-safe did not enable the wake pin");

  a_softrst_can: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.soft_reset |=> can_mode_o == ($past(dev_mode_i) ? CAN_NORMAL : CAN_OFF))
    else $error("soft reset transceiver mode wrong");

  a_stop_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.stop_to_normal |=> !stop_wdog_disable_b_o && !stop_wdog_off_o)
    else $error("second disable bit survived stop to normal");

  a_restart_iwk: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.restart && !evt_i.soft_reset |=> st.iwk == ($past(st.iwk) & IWK_RST_KEEP))
    else $error("internal wake control wrong after restart");

  a_restart_ewk: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.restart && !evt_i.soft_reset |=> st.ewk == ($past(st.ewk) & EWK_RST_KEEP))
    else $error("external wake control wrong after restart");

  a_stop_off: assert property (@(posedge mclk_i) disable iff (!rst_n)
    stop_wdog_off_o == (stop_wdog_disable_a_o && stop_wdog_disable_b_o))
    else $error("stop-mode watchdog off disagrees with disable bits");

  a_period_map: assert property (@(posedge mclk_i) disable iff (!rst_n)
    watchdog_period_ms_o == wbwc_period_ms(watchdog_period_select_o))
    else $error("watchdog period does not match code");

  a_vsense_refuse: assert property (@(posedge mclk_i) disable iff (!rst_n)
    vsense_refused && !evt_i.soft_reset && !evt_i.restart && !evt_i.fail_safe
      |=> spi_fail_set_o && voltage_sense_select_o == $past(voltage_sense_select_o))
    else $error("sensing select write not refused");

  a_pin_events: assert property (@(posedge mclk_i) disable iff (!rst_n)
    voltage_sense_select_o |-> !wake_pin_events_o)
    else $error("wake pin events while sensing");

  a_write_wdog: assert property (@(posedge mclk_i) disable iff (!rst_n)
    req.valid && req.wr && req.addr == ADDR_WATCHDOG_CONFIGURATION
      && !evt_i.soft_reset && !evt_i.restart && !evt_i.fail_safe
      |=> st.wd == ($past(req.data) & WD_MASK))
    else $error("watchdog config write not applied");

  a_write_bus: assert property (@(posedge mclk_i) disable iff (!rst_n)
    req.valid && req.wr && req.addr == ADDR_TRANSCEIVER_MODE_CONTROL
      && !evt_i.soft_reset && !evt_i.restart && !evt_i.fail_safe
      |=> st.bus == ($past(req.data) & BUS_MASK))
    else $error("transceiver mode write not applied");

  a_write_iwk: assert property (@(posedge mclk_i) disable iff (!rst_n)
    req.valid && req.wr && req.addr == ADDR_INTERNAL_WAKE_CONTROL && !evt_i.stop_to_normal
      && !evt_i.soft_reset && !evt_i.restart && !evt_i.fail_safe
      |=> st.iwk == ($past(req.data) & IWK_MASK))
    else $error("internal wake write not applied");

  a_write_ewk: assert property (@(posedge mclk_i) disable iff (!rst_n)
    req.valid && req.wr && req.addr == ADDR_EXTERNAL_WAKE_CONTROL && !vsense_refused
      && !evt_i.soft_reset && !evt_i.restart && !evt_i.fail_safe
      |=> st.ewk == ($past(req.data) & EWK_MASK))
    else $error("external wake write not applied");

  a_softrst_regs: assert property (@(posedge mclk_i) disable iff (!rst_n)
    evt_i.soft_reset |=> st.wd == WD_POR && st.iwk == IWK_POR && st.ewk == EWK_POR)
    else $error("soft reset values wrong");

  a_dev_init: assert property (@(posedge mclk_i) disable iff (!rst_n)
    st.init_pending && dev_mode_i && !evt_i.restart && !evt_i.fail_safe && !req.valid
      |=> can_mode_o == CAN_NORMAL)
    else $error("development mode did not start transceiver normal");

  // Without a frame or an event nothing may move, so partial frames leave no trace
  a_idle_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !req.valid && evt_i == '0 && !st.init_pending
      |=> st.wd == $past(st.wd) && st.bus == $past(st.bus)
        && st.iwk == $past(st.iwk) && st.ewk == $past(st.ewk))
    else $error("register changed without frame or event");

  a_fail_cause: assert property (@(posedge mclk_i) disable iff (!rst_n)
    spi_fail_set_o |-> $past(vsense_refused))
    else $error("serial failure flag without refused write");

endmodule // wbwc_ctrl_regs

// ===== wbwc_ctrl_regs_tb.sv
// Self-checking bench of the watchdog, bus and wake control register bank.
// Assumes wbwc_host_model drives the serial pins; events and straps come from here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module wbwc_ctrl_regs_tb;
  import wbwc_pkg::*;
  localparam logic [6:0] WD = ADDR_WATCHDOG_CONFIGURATION;
  localparam logic [6:0] BUS = ADDR_TRANSCEIVER_MODE_CONTROL;
  localparam logic [6:0] IWK = ADDR_INTERNAL_WAKE_CONTROL;
  localparam logic [6:0] EWK = ADDR_EXTERNAL_WAKE_CONTROL;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic dev_mode_i = 1'b0;
  logic fail_out_active_i = 1'b0;
  wbwc_evt_t evt_i = '0;
  logic sck_i, csn_b_i, sdi_i, sdo_o, stop_wdog_disable_a_o, watchdog_type_select_o;
  logic watchdog_start_on_bus_wake_o, stop_wdog_off_o, cyclic_timer_wake_enable_o;
  logic stop_wdog_disable_b_o, interrupt_scope_all_o, voltage_sense_select_o;
  logic wake_pin_enable_o, wake_pin_events_o, spi_fail_set_o;
  logic [2:0] watchdog_period_select_o;
  logic [13:0] watchdog_period_ms_o;
  logic [1:0] can_mode_o;
  logic [13:0] per_ms [8] = '{14'd10, 14'd20, 14'd50, 14'd100, 14'd200, 14'd500,
                              14'd1000, 14'd10000};
  int err_count = 0;
  int num_checks = 0;
  logic fail_seen = 1'b0;

  wbwc_ctrl_regs i_dut (
    .mclk_i, .rst_b_i, .sck_i, .csn_b_i, .sdi_i, .dev_mode_i, .fail_out_active_i, .evt_i,
    .sdo_o, .stop_wdog_disable_a_o, .watchdog_type_select_o, .watchdog_start_on_bus_wake_o,
    .watchdog_period_select_o, .watchdog_period_ms_o, .stop_wdog_off_o, .can_mode_o,
    .cyclic_timer_wake_enable_o, .stop_wdog_disable_b_o, .interrupt_scope_all_o,
    .voltage_sense_select_o, .wake_pin_enable_o, .wake_pin_events_o, .spi_fail_set_o
  );
  wbwc_host_model i_host (.mclk_i, .sdo_i(sdo_o), .sck_o(sck_i), .csn_b_o(csn_b_i),
                          .sdi_o(sdi_i));

  // ==========================================================
  // Clock, flag catcher and shared bus tasks
  initial forever #50 mclk_i = ~mclk_i;
  // The refusal flag is a single-cycle pulse, so it is caught here
  always @(posedge mclk_i) if (spi_fail_set_o === 1'b1) fail_seen <= 1'b1;

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.frame({1'b1, a, d}, 16, 3, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    i_host.frame({1'b0, a, 8'h00}, 16, 3, v);
  endtask
  function automatic wbwc_evt_t ev(input logic [3:0] f, input logic [1:0] m);
    return wbwc_evt_t'({f, m});
  endfunction
  task automatic pulse(input wbwc_evt_t e);
    evt_i = e;
    @(negedge mclk_i);
    evt_i = '0;
    repeat (2) @(negedge mclk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_por;
    logic [7:0] v;
    `CHK("period", 14'd200, watchdog_period_ms_o)
    `CHK("events", 1'b1, wake_pin_events_o)
    rd(WD, v);
    `CHK("wd", 8'h14, v)
    rd(EWK, v);
    `CHK("ewk", 8'h01, v)
    rd(7'h10, v);
    `CHK("unmapped", 8'h00, v)
  endtask
  task automatic t_wdog;
    logic [7:0] d, v;
    for (int c = 0; c < 8; c++) begin
      d = i_host.wd_sum({1'b0, c[2:0], c[0], c[2:0]});
      wr(WD, d);
      rd(WD, v);
      `CHK("wd rd", d & 8'hf7, v)
      `CHK("stop a", c[2], stop_wdog_disable_a_o)
      `CHK("type", c[1], watchdog_type_select_o)
      `CHK("bus wake", c[0], watchdog_start_on_bus_wake_o)
      `CHK("code", c[2:0], watchdog_period_select_o)
      `CHK("ms", per_ms[c], watchdog_period_ms_o)
    end
  endtask
  task automatic t_can;
    logic [7:0] v;
    for (int m = 0; m < 4; m++) begin
      wr(BUS, {6'h3f, m[1:0]});
      rd(BUS, v);
      `CHK("can", m[1:0], can_mode_o)
      `CHK("bus rd", {6'h00, m[1:0]}, v)
    end
  endtask
  task automatic t_iwk;
    logic [7:0] v;
    wr(WD, i_host.wd_sum(8'h40));
    wr(IWK, 8'hff);
    rd(IWK, v);
    `CHK("iwk rd", 8'h44, v)
    `CHK("timer", 1'b1, cyclic_timer_wake_enable_o)
    `CHK("wd off", 1'b1, stop_wdog_off_o)
    pulse(ev(4'b0001, 2'h0));
    `CHK("stop b", 1'b0, stop_wdog_disable_b_o)
    `CHK("wd off", 1'b0, stop_wdog_off_o)
    wr(IWK, 8'h04);
    `CHK("timer", 1'b0, cyclic_timer_wake_enable_o)
    `CHK("stop b", 1'b1, stop_wdog_disable_b_o)
    wr(WD, i_host.wd_sum(8'h00));
    `CHK("wd off", 1'b0, stop_wdog_off_o)
  endtask
  task automatic t_ewk;
    logic [7:0] v;
    wr(EWK, 8'hff);
    rd(EWK, v);
    `CHK("ewk rd", 8'ha1, v)
    `CHK("scope", 1'b1, interrupt_scope_all_o)
    `CHK("sense", 1'b1, voltage_sense_select_o)
    `CHK("events", 1'b0, wake_pin_events_o)
    wr(EWK, 8'h01);
    `CHK("scope", 1'b0, interrupt_scope_all_o)
    `CHK("events", 1'b1, wake_pin_events_o)
    wr(EWK, 8'h00);
    `CHK("pin", 1'b0, wake_pin_enable_o)
  endtask
  task automatic t_restart;
    logic [7:0] v;
    wr(WD, i_host.wd_sum(8'h77));
    wr(BUS, 8'h03);
    wr(IWK, 8'h44);
    wr(EWK, 8'ha1);
    pulse(ev(4'b0100, CAN_RECEIVE_ONLY));
    `CHK("ms", 14'd200, watchdog_period_ms_o)
    rd(WD, v);
    `CHK("wd", 8'h34, v)
    rd(BUS, v);
    `CHK("bus", 8'h02, v)
    rd(IWK, v);
    `CHK("iwk", 8'h40, v)
    rd(EWK, v);
    `CHK("ewk", 8'ha1, v)
  endtask
  task automatic t_fail;
    logic [7:0] v;
    wr(BUS, 8'h03);
    wr(EWK, 8'h80);
    pulse(ev(4'b0010, 2'h0));
    rd(BUS, v);
    `CHK("bus", 8'h01, v)
    rd(EWK, v);
    `CHK("ewk", 8'h81, v)
    wr(EWK, 8'ha0);
    pulse(ev(4'b0010, 2'h0));
    rd(EWK, v);
    `CHK("ewk", 8'ha0, v)
  endtask
  task automatic t_refuse;
    logic [7:0] v;
    wr(EWK, 8'h00);
    fail_out_active_i = 1'b1;
    fail_seen = 1'b0;
    wr(EWK, 8'h21);
    `CHK("fail flag", 1'b1, fail_seen)
    rd(EWK, v);
    `CHK("ewk", 8'h00, v)
    wr(EWK, 8'h81);
    rd(EWK, v);
    `CHK("ewk", 8'h81, v)
    fail_out_active_i = 1'b0;
  endtask
  task automatic t_short;
    logic [7:0] v;
    // Twelve clocks that leave a whole write of mode 3 in the shifter
    wr(BUS, 8'h08);
    i_host.frame(16'h4030, 12, 3, v);
    `CHK("can", CAN_OFF, can_mode_o)
    i_host.frame({1'b0, EWK, 8'h00}, 16, 6, v);
    `CHK("slow rd", 8'h81, v)
  endtask
  task automatic t_soft;
    logic [7:0] v;
    dev_mode_i = 1'b1;
    pulse(ev(4'b1000, 2'h0));
    `CHK("can", CAN_NORMAL, can_mode_o)
    rd(EWK, v);
    `CHK("ewk", 8'h01, v)
    dev_mode_i = 1'b0;
    pulse(ev(4'b1000, 2'h0));
    `CHK("can", CAN_OFF, can_mode_o)
  endtask
  task automatic t_dev_por;
    logic [7:0] v;
    dev_mode_i = 1'b1;
    rst_b_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    `CHK("can", CAN_NORMAL, can_mode_o)
    rd(BUS, v);
    `CHK("bus", 8'h03, v)
    rd(EWK, v);
    `CHK("ewk", 8'h01, v)
    dev_mode_i = 1'b0;
  endtask

  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic report_and_stop;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // About 6500 cycles are needed; the margin covers slow serial phases
  initial begin
    repeat (50000) @(posedge mclk_i);
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    t_por;
    t_wdog;
    t_can;
    t_iwk;
    t_ewk;
    t_restart;
    t_fail;
    t_refuse;
    t_short;
    t_soft;
    t_dev_por;
    report_and_stop;
  end
endmodule // wbwc_ctrl_regs_tb

// ===== wbwc_host_model.sv
// Host microcontroller model that drives serial frames into the control register bank.
// Assumes it is clocked by mclk and changes its pins on the falling mclk edge.
`timescale 1ns/1ps
module wbwc_host_model (
  input wire logic mclk_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic csn_b_o,
  output logic sdi_o
);
  // ==========================================================
  // Idle pins: clock stands low, data shows the inverse of its last bit
  initial begin
    sck_o = 1'b0;
    csn_b_o = 1'b1;
    sdi_o = 1'b0;
  end

  // ==========================================================
  // Watchdog settings carry bit 7 so that all eight bits have even parity
  function automatic logic [7:0] wd_sum(input logic [7:0] d);
    return {^d[6:0], d[6:0]};
  endfunction

  // Half is the count of mclk cycles per serial clock phase; the design needs at least 2
  task automatic frame(input logic [15:0] word, input int nbits, input int half,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(negedge mclk_i);
    csn_b_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi_o = word[15 - i];
      repeat (half) @(negedge mclk_i);
      if (i >= 8) begin
        rd = {rd[6:0], sdo_i};
      end
      sck_o = 1'b1;
      repeat (half) @(negedge mclk_i);
      sck_o = 1'b0;
    end
    repeat (half) @(negedge mclk_i);
    csn_b_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (4) @(negedge mclk_i);
  endtask
endmodule // wbwc_host_model

// ===== wbwc_pkg.sv
// Constants, field layouts and carrier types of the watchdog, bus and wake control registers.
// Assumes one 10 MHz clock; the serial frame is 16 bits, MSB first.
package wbwc_pkg;

  // ==========================================================
  // Register addresses (7-bit serial address)
  localparam logic [6:0] ADDR_WATCHDOG_CONFIGURATION = 7'h03;
  localparam logic [6:0] ADDR_TRANSCEIVER_MODE_CONTROL = 7'h04;
  localparam logic [6:0] ADDR_INTERNAL_WAKE_CONTROL = 7'h06;
  localparam logic [6:0] ADDR_EXTERNAL_WAKE_CONTROL = 7'h07;

  // ==========================================================
  // Implemented bits, power-on values, restart and fail-safe patterns
  localparam logic [7:0] WD_MASK = 8'hf7;
  localparam logic [7:0] WD_POR = 8'h14;
  localparam logic [7:0] WD_RST_KEEP = 8'hb0;
  localparam logic [7:0] WD_RST_VAL = 8'h04;
  localparam logic [7:0] BUS_MASK = 8'h03;
  localparam logic [7:0] BUS_POR = 8'h00;
  localparam logic [7:0] BUS_FAIL_SAFE = 8'h01;
  localparam logic [7:0] IWK_MASK = 8'h44;
  localparam logic [7:0] IWK_POR = 8'h00;
  localparam logic [7:0] IWK_RST_KEEP = 8'h40;
  localparam logic [7:0] EWK_MASK = 8'ha1;
  localparam logic [7:0] EWK_POR = 8'h01;
  localparam logic [7:0] EWK_RST_KEEP = 8'ha1;
  localparam logic [7:0] EWK_FS_KEEP = 8'ha0;
  localparam logic [7:0] EWK_FS_SET = 8'h01;

  // ==========================================================
  // Field positions
  localparam int WD_STOP_DISABLE_A_BIT = 6;
  localparam int WD_TYPE_BIT = 5;
  localparam int WD_BUS_WAKE_BIT = 4;
  localparam int WD_PERIOD_LSB = 0;
  localparam int IWK_TIMER_WAKE_BIT = 6;
  localparam int IWK_STOP_DISABLE_B_BIT = 2;
  localparam int EWK_INT_SCOPE_BIT = 7;
  localparam int EWK_VSENSE_BIT = 5;
  localparam int EWK_PIN_ENABLE_BIT = 0;

  // ==========================================================
  // Transceiver modes
  localparam logic [1:0] CAN_OFF = 2'h0;
  localparam logic [1:0] CAN_WAKE_CAPABLE = 2'h1;
  localparam logic [1:0] CAN_RECEIVE_ONLY = 2'h2;
  localparam logic [1:0] CAN_NORMAL = 2'h3;

  // ==========================================================
  // Watchdog periods in milliseconds, one per period code
  localparam logic [13:0] WD_PER_0_MS = 14'd10;
  localparam logic [13:0] WD_PER_1_MS = 14'd20;
  localparam logic [13:0] WD_PER_2_MS = 14'd50;
  localparam logic [13:0] WD_PER_3_MS = 14'd100;
  localparam logic [13:0] WD_PER_4_MS = 14'd200;
  localparam logic [13:0] WD_PER_5_MS = 14'd500;
  localparam logic [13:0] WD_PER_6_MS = 14'd1000;
  localparam logic [13:0] WD_PER_7_MS = 14'd10000;

  // ==========================================================
  // Serial frame
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;
  localparam logic [4:0] SPI_ADDR_BITS = 5'd8;
  localparam logic [4:0] SPI_OVERRUN = 5'd17;
  localparam int SPI_WR_BIT = 15;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } wbwc_req_t;

  typedef struct packed {
    logic soft_reset;
    logic restart;
    logic fail_safe;
    logic stop_to_normal;
    logic [1:0] restart_can_mode;
  } wbwc_evt_t;

  typedef struct packed {
    logic sck_d;
    logic csn_d;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [7:0] out;
    logic sdo;
    wbwc_req_t req;
  } wbwc_spi_state_t;

  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] bus;
    logic [7:0] iwk;
    logic [7:0] ewk;
    logic init_pending;
    logic spi_fail;
    logic stop_off;
    logic pin_wake;
    logic [13:0] period_ms;
  } wbwc_state_t;

  // Period code to milliseconds; used by the logic and its checks
  function automatic logic [13:0] wbwc_period_ms(input logic [2:0] code);
    logic [13:0] ms;
    ms = WD_PER_0_MS;
    unique case (code)
      3'h0: ms = WD_PER_0_MS;
      3'h1: ms = WD_PER_1_MS;
      3'h2: ms = WD_PER_2_MS;
      3'h3: ms = WD_PER_3_MS;
      3'h4: ms = WD_PER_4_MS;
      3'h5: ms = WD_PER_5_MS;
      3'h6: ms = WD_PER_6_MS;
      3'h7: ms = WD_PER_7_MS;
    endcase
    return ms;
  endfunction

endpackage

// ===== wbwc_spi_frame.sv
// Serial frame receiver and read-data shifter (clock idle low, sample on rising edge).
// Assumes serial pins already synchronous to mclk and a serial clock at most mclk/4.
`timescale 1ns/1ps
module wbwc_spi_frame
  import wbwc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic csn_b_i,
  input wire logic sdi_i,
  input wire logic [7:0] rd_data_i,
  output logic [6:0] addr_o,
  output logic sdo_o,
  output wbwc_pkg::wbwc_req_t req_o
);
  import wbwc_pkg::*;

  wbwc_spi_state_t st;
  wbwc_spi_state_t next_st;

  // ==========================================================
  // Frame sequencing
  always_comb begin
    next_st = st;
    next_st.sck_d = sck_i;
    next_st.csn_d = csn_b_i;
    next_st.req = '0;
    if (csn_b_i) begin
      // Only a frame of exactly sixteen clocks is applied, and only at its end
      if (!st.csn_d && st.cnt == SPI_FRAME_BITS) begin
        next_st.req.valid = 1'b1;
        next_st.req.wr = st.sh[SPI_WR_BIT];
        next_st.req.addr = st.sh[14:8];
        next_st.req.data = st.sh[7:0];
      end
      next_st.cnt = '0;
      next_st.out = '0;
      next_st.sdo = 1'b0;
    end else if (sck_i && !st.sck_d) begin
      next_st.sh = {st.sh[14:0], sdi_i};
      if (st.cnt != SPI_OVERRUN) begin
        next_st.cnt = st.cnt + 5'd1;
      end
    end else if (!sck_i && st.sck_d) begin
      // Reply shows the register as it stood before this frame's write
      if (st.cnt == SPI_ADDR_BITS) begin
        next_st.sdo = rd_data_i[7];
        next_st.out = {rd_data_i[6:0], 1'b0};
      end else if (st.cnt > SPI_ADDR_BITS) begin
        next_st.sdo = st.out[7];
        next_st.out = {st.out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{sck_d: 1'b0, csn_d: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign addr_o = st.sh[6:0];
  assign sdo_o = st.sdo;
  assign req_o = st.req;

  // ==========================================================
  // Checks
  a_frame_whole: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    req_o.valid |-> csn_b_i && $past(st.cnt) == SPI_FRAME_BITS)
    else $error("request issued without a complete frame");

endmodule // wbwc_spi_frame
